// ==== rtl/din_cond.sv ====
/*
  Synchroniser and edge detector for the discrete inputs.
  Assumes raw inputs may change at any time relative to the clock.
*/
`timescale 1ns/1ns
`default_nettype none
module din_cond #(parameter int N = 9) (
  input wire logic clk, // System clock
  input wire logic rstn, // Synchronous reset, active low
  input wire logic [N-1:0] raw, // Raw discrete inputs
  din_if.src d // Conditioned levels and edges
);
  logic [N-1:0] s1_q; // First stage, read by s2_q only
  logic [N-1:0] s2_q;
  logic [N-1:0] s3_q;

  // Two-stage synchroniser plus a delay stage for edges
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= raw;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Levels and single-cycle edge pulses
  assign d.lvl = s2_q;
  assign d.rise = s2_q & ~s3_q;
  assign d.fall = ~s2_q & s3_q;
endmodule
`default_nettype wire

// ==== rtl/din_if.sv ====
/*
  Carrier for conditioned discrete inputs: synchronised levels and
  one-cycle rising and falling pulses.
  Assumes one clock for both ends.
*/
`timescale 1ns/1ns
`default_nettype none
interface din_if #(parameter int N = 9);
  logic [N-1:0] lvl;
  logic [N-1:0] rise;
  logic [N-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface
`default_nettype wire

// ==== rtl/weigh_io_pkg.sv ====
/*
  Constants shared by the discrete I/O control block of the weighing
  indicator: input indices, register map, control and status bit
  positions, reset values and the complete output timing.
  Assumes a 100 MHz system clock.
*/
package weigh_io_pkg;

  // Default weight word width
  localparam int W_DEF = 24;

  // Positions of the discrete inputs on the DIN vector
  localparam int IN_VIEW = 0;
  localparam int IN_ZERO = 1;
  localparam int IN_TARE = 2;
  localparam int IN_TCLR = 3;
  localparam int IN_DIR = 4;
  localparam int IN_HOLD = 5;
  localparam int IN_INH = 6;
  localparam int IN_START = 7;
  localparam int IN_STOP = 8;
  localparam int IN_N = 9;

  // Register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_FINAL = 8'h04;
  localparam logic [7:0] OFF_OVER = 8'h08;
  localparam logic [7:0] OFF_UNDER = 8'h0c;
  localparam logic [7:0] OFF_COMP = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_GROSS = 8'h18;
  localparam logic [7:0] OFF_NET = 8'h1c;
  localparam logic [7:0] OFF_TARE = 8'h20;

  // Control register fields
  localparam int CB_SEQ = 0;
  localparam int CB_DIR_EXT = 1;
  localparam int CB_OU_EXT = 2;
  localparam int CB_UL_EXT = 3;
  localparam int CB_CMP_NET = 4;
  localparam int CB_DIR_SW = 5;
  localparam int CB_JCNT_LO = 8;
  localparam int JCNT_W = 7;
  localparam logic [31:0] CTRL_RST = 32'h0000_0100;
  localparam logic [31:0] CTRL_MASK = 32'h0000_7f3f;

  // Status register fields
  localparam int SB_NET = 0;
  localparam int SB_STABLE = 1;
  localparam int SB_OVER = 2;
  localparam int SB_UNDER = 3;
  localparam int SB_GO = 4;
  localparam int SB_FAULT = 5;
  localparam int SB_BUSY = 6;
  localparam int SB_DISCH = 7;
  localparam int SB_SP3 = 8;
  localparam int SB_CMPL = 9;

  // Bus responses
  localparam logic [1:0] RESP_OK = 2'h0;
  localparam logic [1:0] RESP_ERR = 2'h2;

  // Complete output duration in sequence mode
  localparam int CLK_NS = 10;
  localparam int COMPLETE_NS = 1000;
  localparam int COMPLETE_CYC = (COMPLETE_NS + CLK_NS - 1) / CLK_NS;

  // Weighing sequence states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_FEED = 3'b010,
    ST_DONE = 3'b100
  } seq_st_t;

endpackage

// ==== rtl/weigh_io_top.sv ====
/*
  Discrete I/O control of a weighing indicator with an AXI4-Lite
  register slave. Assumes WEIGHT_IN and MOTION_OK are synchronous to
  CLK and that the bus master keeps one write and one read in flight.
*/
// Our own choices: the AXI4-Lite register port and the address map.
// What this block does
// - View input rise shows net, fall gross
// - Zero input rise zeroes gross weight
// - Tare input rise captures tare, net zero
// - Tare-clear input rise cancels tare
// - External selection: direction level picks feed/discharge
// - Shared input judges if CB_OU_EXT set, holds if CB_UL_EXT also clear
// - Hold freezes weight and results; sequence ignores
// - Judging role compares only while input high if CB_OU_EXT set, else always
// - Inhibit high suspends third set-point comparison
// - Sequence cycle starts on start rising edge
// - Stop high during cycle aborts, raises fault
// - Stop rising edge clears pending fault
// - Stable output follows motion detector
// - Simple mode judgment timed by compare setting
// - Sequence judging compares during complete, holds weight
// - Under, over, go limits around final setpoint
// - Comparison uses gross or net per setting
// - Judge count: 0 off, 1 every, N-th
`timescale 1ns/1ns
`default_nettype none
module weigh_io_top
  import weigh_io_pkg::*;
#(parameter int W = weigh_io_pkg::W_DEF) (
  input wire logic CLK, // System clock
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic [W-1:0] WEIGHT_IN, // Raw weight from front end
  input wire logic MOTION_OK, // Motion detector: weight stable
  input wire logic [weigh_io_pkg::IN_N-1:0] DIN, // Discrete inputs
  output logic [W-1:0] WEIGHT_OUT, // Displayed weight
  output logic NET_SHOWN, // Net weight on display
  output logic STABLE, // Stable output
  output logic OVER, // Over output
  output logic UNDER, // Under output
  output logic GO, // Go output
  output logic SP3, // Third set point reached
  output logic DISCHARGE, // Discharging control selected
  output logic COMPLETE, // Weighing complete
  output logic BUSY, // Weighing cycle in progress
  output logic SEQ_FAULT, // Sequence fault
  input wire logic [7:0] AWADDR, // Write address
  input wire logic AWVALID, // Write address valid
  output logic AWREADY, // Write address ready
  input wire logic [31:0] WDATA, // Write data
  input wire logic [3:0] WSTRB, // Write byte strobes
  input wire logic WVALID, // Write data valid
  output logic WREADY, // Write data ready
  output logic [1:0] BRESP, // Write response
  output logic BVALID, // Write response valid
  input wire logic BREADY, // Write response ready
  input wire logic [7:0] ARADDR, // Read address
  input wire logic ARVALID, // Read address valid
  output logic ARREADY, // Read address ready
  output logic [31:0] RDATA, // Read data
  output logic [1:0] RRESP, // Read response
  output logic RVALID, // Read valid
  input wire logic RREADY // Read ready
);
  import weigh_io_pkg::*;

  // Merge write data into a word under byte strobes
  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] nw, input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (st[i]) begin
        r[8*i +: 8] = nw[8*i +: 8];
      end
    end
    merge = r;
  endfunction

  din_if #(.N(IN_N)) din ();

  din_cond #(.N(IN_N)) u_cond (
    .clk(CLK),
    .rstn(RSTN),
    .raw(DIN),
    .d(din)
  );

  // Configuration and weight state
  logic [31:0] ctrl_q;
  logic [W-1:0] final_q, over_q, under_q, comp_q;
  logic [W-1:0] zoff_q, tare_q, hold_w_q;
  logic net_q, stable_q, over_o_q, under_o_q, go_q, sp3_q;
  logic disch_q, fault_q, judge_on_q;
  logic [JCNT_W-1:0] wcnt_q;
  logic [7:0] ccnt_q;
  seq_st_t st_q, st_d;

  // Bus state
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q, rdata_d;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q, rresp_d;

  // Control fields
  wire seq = ctrl_q[CB_SEQ];
  wire ou_ext = ctrl_q[CB_OU_EXT];
  wire judge_role = ctrl_q[CB_OU_EXT] | ctrl_q[CB_UL_EXT];
  wire [JCNT_W-1:0] jcnt = ctrl_q[CB_JCNT_LO +: JCNT_W];
  wire hold_in = din.lvl[IN_HOLD];

  // Gross, net and comparison weight
  wire [W-1:0] gross = WEIGHT_IN - zoff_q;
  wire [W-1:0] net = gross - tare_q;
  wire [W-1:0] cmp_w = ctrl_q[CB_CMP_NET] ? net : gross;
  wire [W-1:0] live_w = net_q ? net : gross;

  // Hold role freezes only in simple mode
  wire freeze = !seq && !judge_role && hold_in;
  wire seq_judge = seq && (st_q == ST_DONE) && judge_on_q;
  wire upd_simple = ou_ext ? hold_in : !freeze;
  wire upd = seq ? seq_judge : upd_simple;
  wire hold_w = freeze || seq_judge;

  logic j_over, j_under, j_go, j_sp3;

  weigh_judge #(.W(W)) u_judge (
    .weight(hold_w_q),
    .final_sp(final_q),
    .over_tol(over_q),
    .under_tol(under_q),
    .comp(comp_q),
    .over(j_over),
    .under(j_under),
    .go(j_go),
    .sp3(j_sp3)
  );

  // Sequence events
  wire in_cycle = (st_q != ST_IDLE);
  wire start_ev = seq && (st_q == ST_IDLE) && din.rise[IN_START];
  wire abort = seq && in_cycle && din.lvl[IN_STOP];
  wire [JCNT_W-1:0] wnext = wcnt_q + JCNT_W'(1);
  wire judge_now = (jcnt != '0) && (wnext >= jcnt);

  // Sequence state transitions
  always_comb begin
    st_d = st_q;
    case (st_q)
      ST_IDLE: begin
        if (start_ev) begin
          st_d = ST_FEED;
        end
      end
      ST_FEED: begin
        if (!seq || abort) begin
          st_d = ST_IDLE;
        end else if (sp3_q && stable_q) begin
          st_d = ST_DONE;
        end
      end
      ST_DONE: begin
        if (!seq || abort || ccnt_q == 8'(COMPLETE_CYC - 1)) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  // Sequence state, judge counter and complete timer
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      st_q <= ST_IDLE;
      wcnt_q <= '0;
      judge_on_q <= 1'b0;
      ccnt_q <= 8'h00;
    end else begin
      st_q <= st_d;
      ccnt_q <= (st_q == ST_DONE) ? ccnt_q + 8'h01 : 8'h00;
      if (start_ev) begin
        judge_on_q <= judge_now;
        wcnt_q <= judge_now ? '0 : wnext;
      end
    end
  end

  // Fault: a new abort wins over a clearing edge
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      fault_q <= 1'b0;
    end else if (abort) begin
      fault_q <= 1'b1;
    end else if (din.rise[IN_STOP]) begin
      fault_q <= 1'b0;
    end
  end

  // Zero, tare and view selection from input edges
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      zoff_q <= '0;
      tare_q <= '0;
      net_q <= 1'b0;
    end else begin
      if (din.rise[IN_VIEW]) begin
        net_q <= 1'b1;
      end else if (din.fall[IN_VIEW]) begin
        net_q <= 1'b0;
      end
      if (din.rise[IN_ZERO]) begin
        zoff_q <= WEIGHT_IN;
      end
      if (din.rise[IN_TCLR]) begin
        tare_q <= '0;
      end else if (din.rise[IN_TARE]) begin
        tare_q <= gross;
      end
    end
  end

  // Weight hold, outputs and comparison results
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      hold_w_q <= '0;
      WEIGHT_OUT <= '0;
      stable_q <= 1'b0;
      over_o_q <= 1'b0;
      under_o_q <= 1'b0;
      go_q <= 1'b0;
      sp3_q <= 1'b0;
      disch_q <= 1'b0;
    end else begin
      stable_q <= MOTION_OK;
      if (!hold_w) begin
        hold_w_q <= cmp_w;
        WEIGHT_OUT <= live_w;
      end
      if (start_ev) begin
        over_o_q <= 1'b0;
        under_o_q <= 1'b0;
        go_q <= 1'b0;
      end else if (upd) begin
        over_o_q <= j_over;
        under_o_q <= j_under;
        go_q <= j_go;
      end
      if (!din.lvl[IN_INH] && !freeze) begin
        sp3_q <= j_sp3;
      end
      disch_q <= ctrl_q[CB_DIR_EXT] ? din.lvl[IN_DIR]
                                    : ctrl_q[CB_DIR_SW];
    end
  end

  // Output flops; complete and busy are decoded from the state register
  assign NET_SHOWN = net_q;
  assign STABLE = stable_q;
  assign OVER = over_o_q;
  assign UNDER = under_o_q;
  assign GO = go_q;
  assign SP3 = sp3_q;
  assign DISCHARGE = disch_q;
  assign COMPLETE = (st_q == ST_DONE);
  assign BUSY = in_cycle;
  assign SEQ_FAULT = fault_q;

  // Write address decode
  wire w_ctrl = awaddr_q == OFF_CTRL;
  wire w_final = awaddr_q == OFF_FINAL;
  wire w_over = awaddr_q == OFF_OVER;
  wire w_under = awaddr_q == OFF_UNDER;
  wire w_comp = awaddr_q == OFF_COMP;
  wire w_ro = (awaddr_q == OFF_STATUS) || (awaddr_q == OFF_GROSS) ||
              (awaddr_q == OFF_NET) || (awaddr_q == OFF_TARE);
  wire w_hit = w_ctrl || w_final || w_over || w_under || w_comp || w_ro;
  wire wr_go = !awready_q && !wready_q && !bvalid_q;

  // Write channels: accept address and data in any order
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      bvalid_q <= 1'b0;
      bresp_q <= RESP_OK;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (AWVALID && awready_q) begin
        awaddr_q <= AWADDR;
        awready_q <= 1'b0;
      end
      if (WVALID && wready_q) begin
        wdata_q <= WDATA;
        wstrb_q <= WSTRB;
        wready_q <= 1'b0;
      end
      if (wr_go) begin
        bvalid_q <= 1'b1;
        bresp_q <= w_hit ? RESP_OK : RESP_ERR;
      end else if (bvalid_q && BREADY) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  // Writable registers
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      ctrl_q <= CTRL_RST;
      final_q <= '0;
      over_q <= '0;
      under_q <= '0;
      comp_q <= '0;
    end else if (wr_go) begin
      if (w_ctrl) begin
        ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & CTRL_MASK;
      end else if (w_final) begin
        final_q <= W'(merge(32'(final_q), wdata_q, wstrb_q));
      end else if (w_over) begin
        over_q <= W'(merge(32'(over_q), wdata_q, wstrb_q));
      end else if (w_under) begin
        under_q <= W'(merge(32'(under_q), wdata_q, wstrb_q));
      end else if (w_comp) begin
        comp_q <= W'(merge(32'(comp_q), wdata_q, wstrb_q));
      end
    end
  end

  // Status word and read selection
  wire [31:0] status = 32'({COMPLETE, sp3_q, disch_q, in_cycle, fault_q,
                            go_q, under_o_q, over_o_q, stable_q, net_q});

  always_comb begin
    rresp_d = RESP_OK;
    if (ARADDR == OFF_CTRL) begin
      rdata_d = ctrl_q;
    end else if (ARADDR == OFF_FINAL) begin
      rdata_d = 32'(final_q);
    end else if (ARADDR == OFF_OVER) begin
      rdata_d = 32'(over_q);
    end else if (ARADDR == OFF_UNDER) begin
      rdata_d = 32'(under_q);
    end else if (ARADDR == OFF_COMP) begin
      rdata_d = 32'(comp_q);
    end else if (ARADDR == OFF_STATUS) begin
      rdata_d = status;
    end else if (ARADDR == OFF_GROSS) begin
      rdata_d = 32'(gross);
    end else if (ARADDR == OFF_NET) begin
      rdata_d = 32'(net);
    end else if (ARADDR == OFF_TARE) begin
      rdata_d = 32'(tare_q);
    end else begin
      rdata_d = 32'h0000_0000;
      rresp_d = RESP_ERR;
    end
  end

  // Read channels
  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= RESP_OK;
    end else if (ARVALID && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q <= 1'b1;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end else if (rvalid_q && RREADY) begin
      rvalid_q <= 1'b0;
      arready_q <= 1'b1;
    end
  end

  assign AWREADY = awready_q;
  assign WREADY = wready_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = arready_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
endmodule
`default_nettype wire

// ==== rtl/weigh_judge.sv ====
/*
  Over, under and go judgment and the third set-point threshold.
  Assumes two's complement weight and setpoint words.
*/
`timescale 1ns/1ns
`default_nettype none
module weigh_judge #(parameter int W = 24) (
  input wire logic [W-1:0] weight, // Weight under comparison
  input wire logic [W-1:0] final_sp, // Final setpoint
  input wire logic [W-1:0] over_tol, // Over tolerance
  input wire logic [W-1:0] under_tol, // Under tolerance
  input wire logic [W-1:0] comp, // Compensation value
  output logic over, // Weight above upper limit
  output logic under, // Weight below lower limit
  output logic go, // Weight within limits
  output logic sp3 // Third set point reached
);
  // Widen by two bits so sums never wrap
  function automatic logic signed [W+1:0] sx(input logic [W-1:0] v);
    sx = signed'({{2{v[W-1]}}, v});
  endfunction

  logic signed [W+1:0] lo;
  logic signed [W+1:0] hi;
  logic signed [W+1:0] wv;

  // Limits and comparisons
  assign lo = sx(final_sp) - sx(under_tol);
  assign hi = sx(final_sp) + sx(over_tol);
  assign wv = sx(weight);
  assign under = wv < lo;
  assign over = wv > hi;
  assign go = (wv >= lo) && (wv <= hi);
  assign sp3 = wv >= (sx(final_sp) - sx(comp));
endmodule
`default_nettype wire

// ==== tb/sw_bank.sv ====
/*
  Model of the external switches and relays on the discrete inputs.
  Assumes the bench asks for levels; each line then stays put at least
  eight cycles before it may change again.
*/
`timescale 1ns/1ns
`default_nettype none
module sw_bank
  import weigh_io_pkg::*;
(
  input wire logic clk, // Bench clock
  input wire logic [weigh_io_pkg::IN_N-1:0] want, // Requested levels
  output logic [weigh_io_pkg::IN_N-1:0] din // Switch levels
);
  logic [IN_N-1:0] lvl_q = '0;
  int age_q [IN_N] = '{default: 7};

  // A line follows its request only after a minimum hold
  always @(posedge clk) begin
    for (int i = 0; i < IN_N; i++) begin
      if (age_q[i] < 7) begin
        age_q[i] <= age_q[i] + 1;
      end else if (lvl_q[i] != want[i]) begin
        lvl_q[i] <= want[i];
        age_q[i] <= 0;
      end
    end
  end
  assign din = lvl_q;
endmodule
`default_nettype wire

// ==== tb/weigh_io_checker.sv ====
/*
  Port-level assertions for the discrete I/O control top module.
  Assumes it is bound to weigh_io_top and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module weigh_io_checker
  import weigh_io_pkg::*;
#(parameter int W = weigh_io_pkg::W_DEF) (
  input wire logic CLK, // System clock
  input wire logic RSTN, // Synchronous reset, active low
  input wire logic MOTION_OK, // Motion detector
  input wire logic [weigh_io_pkg::IN_N-1:0] DIN, // Discrete inputs
  input wire logic [W-1:0] WEIGHT_OUT, // Displayed weight
  input wire logic NET_SHOWN, // Net on display
  input wire logic STABLE, // Stable output
  input wire logic OVER, // Over output
  input wire logic UNDER, // Under output
  input wire logic GO, // Go output
  input wire logic SP3, // Third set point
  input wire logic COMPLETE, // Weighing complete
  input wire logic BUSY, // Cycle in progress
  input wire logic SEQ_FAULT // Sequence fault
);
  int unsigned cmpl_n_q;

  default clocking @(posedge CLK); endclocking
  default disable iff (!RSTN);

  // Counts the cycles the complete output has stood
  always_ff @(posedge CLK) begin
    cmpl_n_q <= (COMPLETE && RSTN) ? cmpl_n_q + 1 : 0;
  end

  AST_STABLE: assert property ($changed(MOTION_OK) |=>
    STABLE == $past(MOTION_OK)) else $error("stable lags motion");
  AST_NET: assert property ($rose(DIN[IN_VIEW]) ##1 DIN[IN_VIEW][*6]
    |-> NET_SHOWN) else $error("net not shown");
  AST_GROSS: assert property ($fell(DIN[IN_VIEW]) ##1
    !DIN[IN_VIEW][*6] |-> !NET_SHOWN) else $error("gross not shown");
  AST_OUG: assert property (!(OVER && UNDER) &&
    !(GO && (OVER || UNDER))) else $error("judgments overlap");
  AST_START: assert property ($rose(BUSY) |-> DIN[IN_START])
    else $error("cycle began without start");
  AST_ABORT: assert property (BUSY && $rose(DIN[IN_STOP]) |->
    ##[2:6] (SEQ_FAULT && !BUSY)) else $error("stop did not abort");
  AST_CLR: assert property (!BUSY && SEQ_FAULT &&
    $rose(DIN[IN_STOP]) |-> ##[2:6] !SEQ_FAULT)
    else $error("fault not cleared");
  // A stop abort may cut the complete window short
  AST_CMPL: assert property ($fell(COMPLETE) && !DIN[IN_STOP] |->
    cmpl_n_q == COMPLETE_CYC) else $error("complete length wrong");
  AST_SEQW: assert property (COMPLETE[*3] |-> $stable(WEIGHT_OUT))
    else $error("weight moved while complete");
  AST_SP3: assert property (DIN[IN_INH][*5] |-> $stable(SP3))
    else $error("set point 3 moved while inhibited");
endmodule

bind weigh_io_top weigh_io_checker #(.W(W)) chk (.CLK(CLK), .RSTN(RSTN),
  .MOTION_OK(MOTION_OK), .DIN(DIN), .WEIGHT_OUT(WEIGHT_OUT),
  .NET_SHOWN(NET_SHOWN), .STABLE(STABLE), .OVER(OVER), .UNDER(UNDER),
  .GO(GO), .SP3(SP3), .COMPLETE(COMPLETE), .BUSY(BUSY),
  .SEQ_FAULT(SEQ_FAULT));
`default_nettype wire

// ==== tb/weighing_discrete_io_control_tb_top.sv ====
/*
  Self-checking bench for the discrete I/O control block.
  Assumes the switch model drives the discrete inputs and registers
  are reached over AXI4-Lite.
*/
`timescale 1ns/1ns
`default_nettype none
module weighing_discrete_io_control_tb_top;
  import weigh_io_pkg::*;
  logic CLK, RSTN, MOTION_OK, NET_SHOWN, STABLE, OVER, UNDER, GO, SP3;
  logic DISCHARGE, COMPLETE, BUSY, SEQ_FAULT;
  logic AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
  logic ARVALID, ARREADY, RVALID, RREADY;
  logic [23:0] WEIGHT_IN, WEIGHT_OUT;
  logic [IN_N-1:0] DIN, want;
  logic [7:0] AWADDR, ARADDR;
  logic [31:0] WDATA, RDATA, rd;
  logic [3:0] WSTRB;
  logic [1:0] BRESP, RRESP, rr;
  logic [15:0] seed;
  int miscompares, tests_run, zoff, tare, g, v, n;
  int cyc = 0;
  int bnd [4] = '{979, 980, 1010, 1011};
  int jcl [3] = '{1, 2, 0};

  weigh_io_top #(.W(24)) dut (.CLK(CLK), .RSTN(RSTN),
    .WEIGHT_IN(WEIGHT_IN), .MOTION_OK(MOTION_OK), .DIN(DIN),
    .WEIGHT_OUT(WEIGHT_OUT), .NET_SHOWN(NET_SHOWN), .STABLE(STABLE),
    .OVER(OVER), .UNDER(UNDER), .GO(GO), .SP3(SP3),
    .DISCHARGE(DISCHARGE), .COMPLETE(COMPLETE), .BUSY(BUSY),
    .SEQ_FAULT(SEQ_FAULT), .AWADDR(AWADDR), .AWVALID(AWVALID),
    .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID),
    .WREADY(WREADY), .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY),
    .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY));
  sw_bank sw (.clk(CLK), .want(want), .din(DIN));

  // Clock
  initial begin
    CLK = 1'b0;
    forever #5 CLK = ~CLK;
  end

  // Hang guard
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      results();
    end
  end

  task automatic results();
    $display("compares %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge CLK);
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    AWADDR <= a;
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (AWVALID && AWREADY) AWVALID <= 1'b0;
      if (WVALID && WREADY) WVALID <= 1'b0;
    end while (!BVALID);
    rr = BRESP;
  endtask

  task automatic axr(input logic [7:0] a);
    ARADDR <= a;
    ARVALID <= 1'b1;
    do begin
      @(posedge CLK);
      if (ARVALID && ARREADY) ARVALID <= 1'b0;
    end while (!RVALID);
    rd = RDATA;
    rr = RRESP;
  endtask

  task automatic put(input int gv);
    g = gv;
    WEIGHT_IN <= 24'(gv + zoff);
  endtask

  task automatic pulse(input int i);
    want[i] <= 1'b1;
    tick(12);
    want[i] <= 1'b0;
    tick(12);
  endtask

  // Expected {over, under, go} for final 1000, over 10, under 20
  function automatic logic [2:0] oug(input int w);
    if (w > 1010) return 3'b100;
    if (w < 980) return 3'b010;
    return 3'b001;
  endfunction

  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  // One weighing in sequence mode, judged or not
  task automatic seq_run(input logic j);
    put(500);
    tick(6);
    want[IN_START] <= 1'b1;
    tick(12);
    want[IN_START] <= 1'b0;
    chk(32'(BUSY), 1);
    put(995);
    n = 0;
    while (!COMPLETE && n < 200) begin tick(1); n++; end
    tick(20);
    if (j) put(2000);
    tick(20);
    chk(32'({OVER, UNDER, GO}), j ? 1 : 0);
    chk(32'(COMPLETE), 1);
    axr(OFF_STATUS);
    chk(rd, 32'h342 | (32'(j) << 4));
    while (BUSY && n < 400) begin tick(1); n++; end
    chk(32'(BUSY), 0);
  endtask

  initial begin
    RSTN = 1'b0; MOTION_OK = 1'b1; WEIGHT_IN = '0; want = '0;
    AWADDR = '0; ARADDR = '0; WDATA = '0; WSTRB = 4'hf;
    AWVALID = 1'b0; WVALID = 1'b0; ARVALID = 1'b0;
    BREADY = 1'b1; RREADY = 1'b1;
    seed = 16'h000a; zoff = 0; tare = 0;
    tick(12);
    RSTN <= 1'b1;
    tick(4);
    axr(OFF_CTRL); chk(rd, CTRL_RST);
    axw(OFF_CTRL, '1); axr(OFF_CTRL); chk(rd, CTRL_MASK);
    axw(8'h40, 32'h1); chk(32'(rr), 32'(RESP_ERR));
    axr(8'h40); chk({rd[29:0], rr}, 32'(RESP_ERR));
    axw(OFF_FINAL, 1000); axw(OFF_OVER, 10); axw(OFF_UNDER, 20);
    axw(OFF_COMP, 30); axw(OFF_CTRL, 32'h100);
    $display("test regs done");
    put(50); tick(4); pulse(IN_ZERO); zoff = 50; g = 0;
    axr(OFF_GROSS); chk(rd, 0);
    put(100); tick(4); pulse(IN_TARE); tare = 100;
    axr(OFF_NET); chk(rd, 0);
    axr(OFF_TARE); chk(rd, 100);
    want[IN_VIEW] <= 1'b1; tick(16);
    chk(32'({NET_SHOWN, WEIGHT_OUT}), 32'h100_0000);
    want[IN_VIEW] <= 1'b0; tick(16);
    chk(32'({NET_SHOWN, WEIGHT_OUT}), 100);
    $display("test zero tare view done");
    for (int cn = 0; cn < 2; cn++) begin
      axw(OFF_CTRL, 32'(32'h100 | (cn << 4)));
      for (int k = 0; k < 12; k++) begin
        seed = lfsr(seed);
        v = (k < 4) ? bnd[k] : 900 + int'(seed % 16'd220);
        put(cn ? v + tare : v);
        tick(6);
        chk(32'({OVER, UNDER, GO}), 32'(oug(v)));
      end
    end
    pulse(IN_TCLR); tare = 0;
    axr(OFF_NET); chk(rd, 32'(g));
    $display("test judge done");
    MOTION_OK <= 1'b0; tick(3); chk(32'(STABLE), 0);
    MOTION_OK <= 1'b1; tick(3); chk(32'(STABLE), 1);
    axw(OFF_CTRL, 32'h102); want[IN_DIR] <= 1'b1; tick(16);
    chk(32'(DISCHARGE), 1);
    want[IN_DIR] <= 1'b0; tick(16); chk(32'(DISCHARGE), 0);
    axw(OFF_CTRL, 32'h120); tick(4); chk(32'(DISCHARGE), 1);
    axw(OFF_CTRL, 32'h100); put(995); tick(6);
    want[IN_HOLD] <= 1'b1; tick(16); put(2000); tick(6);
    chk(32'({OVER, UNDER, GO, WEIGHT_OUT}), 32'h100_03e3);
    want[IN_HOLD] <= 1'b0; tick(16);
    chk(32'({OVER, UNDER, GO}), 4);
    axw(OFF_CTRL, 32'h104); put(995); tick(6);
    chk(32'({OVER, UNDER, GO}), 4);
    want[IN_HOLD] <= 1'b1; tick(16);
    chk(32'({OVER, UNDER, GO}), 1);
    want[IN_HOLD] <= 1'b0; tick(12);
    axw(OFF_CTRL, 32'h100); put(900); tick(6); chk(32'(SP3), 0);
    want[IN_INH] <= 1'b1; tick(16); put(995); tick(6);
    chk(32'(SP3), 0);
    want[IN_INH] <= 1'b0; tick(16); chk(32'(SP3), 1);
    $display("test levels done");
    for (int i = 0; i < 3; i++) begin
      axw(OFF_CTRL, 32'(32'h1 | (jcl[i] << 8)));
      for (int k = 0; k < 2; k++) begin
        seq_run(jcl[i] != 0 && (k + 1) % jcl[i] == 0);
      end
    end
    put(500); tick(6);
    want[IN_START] <= 1'b1; tick(12);
    want[IN_START] <= 1'b0; want[IN_STOP] <= 1'b1; tick(16);
    chk(32'({SEQ_FAULT, BUSY}), 2);
    want[IN_STOP] <= 1'b0; tick(16); pulse(IN_STOP);
    chk(32'(SEQ_FAULT), 0);
    $display("test sequence done");
    results();
  end
endmodule
`default_nettype wire
